// *** inc/vbsm_pkg.sv ***
// Constants and types shared by the video back end register bank.
// Assumes a subaddress write/read port driven by the chip's serial host front end.
package vbsm_pkg;

    // ****************
    // Port widths
    // ****************
    localparam int ADDR_W = 8;
    localparam int DATA_W = 16;
    localparam int REG_W = 9;
    localparam int CTL_W = 8;
    localparam int LINE_W = 9;

    // ****************
    // Subaddresses
    // ****************
    localparam logic [7:0] ADR_STATUS = 8'h1e;
    localparam logic [7:0] ADR_MEAS_CTL = 8'h25;
    localparam logic [7:0] ADR_CUT_BLUE = 8'h42;
    localparam logic [7:0] ADR_CUT_GREEN = 8'h46;
    localparam logic [7:0] ADR_CUT_RED = 8'h4a;
    localparam logic [7:0] ADR_VEL_DELCOR = 8'h4e;
    localparam logic [7:0] ADR_VEL_LIMIT = 8'h52;
    localparam logic [7:0] ADR_VEL_COEF = 8'h5a;
    localparam logic [7:0] ADR_PM_STOP = 8'h6b;
    localparam logic [7:0] ADR_PM_START = 8'h7b;
    localparam logic [7:0] ADR_TUBE_LINE = 8'h7f;

    // ****************
    // Field-latched register slots
    // ****************
    localparam int NUM_VREG = 9;
    localparam int VI_COEF = 0;
    localparam int VI_LIMIT = 1;
    localparam int VI_DELCOR = 2;
    localparam int VI_CUT_R = 3;
    localparam int VI_CUT_G = 4;
    localparam int VI_CUT_B = 5;
    localparam int VI_PM_START = 6;
    localparam int VI_PM_STOP = 7;
    localparam int VI_TUBE_LINE = 8;
    localparam logic [REG_W-1:0] REG_RESET = 9'h000;
    localparam logic [CTL_W-1:0] CTL_RESET = 8'h00;

    // ****************
    // Field positions
    // ****************
    localparam int GAIN_LSB = 0;
    localparam int GAIN_W = 6;
    localparam int DDEL_LSB = 6;
    localparam int DDEL_W = 3;
    localparam logic [DDEL_W-1:0] DDEL_OFF = 3'h0;
    localparam int LIM_LSB = 0;
    localparam int LIM_W = 7;
    localparam int HDEL_LSB = 0;
    localparam int HDEL_W = 4;
    localparam int COR_LSB = 4;
    localparam int COR_W = 4;
    localparam int CTL_TUBE_MEAS_ENABLE = 0;
    localparam int CTL_PICTURE_MEAS_BANDWIDTH = 1;
    localparam int CTL_PICTURE_MEAS_TRIGGER = 2;
    localparam int CTL_PICTURE_MEAS_WINDOW_SIZE = 3;
    localparam int ST_TUBE_DONE = 0;
    localparam int ST_PIC_DONE = 3;

    // Length of the tube measurement sequence, in lines
    localparam logic [3:0] TUBE_MEAS_LINES = 4'h8;

    typedef enum logic [3:0] {
        VBSM_PM_IDLE = 4'b0001,
        VBSM_PM_ARM = 4'b0010,
        VBSM_PM_WAIT = 4'b0100,
        VBSM_PM_RUN = 4'b1000
    } vbsm_pm_state_e;

    typedef enum logic [1:0] {
        VBSM_TM_IDLE = 2'b01,
        VBSM_TM_RUN = 2'b10
    } vbsm_tm_state_e;

endpackage

// *** rtl/vbsm_vlatch.sv ***
// Host-side and working copies of the field-latched registers.
// Assumes vsync is a one-cycle pulse at each field boundary.
`timescale 1ns/1ps
module vbsm_vlatch
    import vbsm_pkg::*;
(
    input wire logic clk, // Display clock
    input wire logic rst, // Asynchronous reset
    input wire logic ce, // Clock enable
    input wire logic [NUM_VREG-1:0] wr_sel, // One-hot write select
    input wire logic [REG_W-1:0] wr_val, // Write value
    input wire logic vsync, // Field boundary pulse
    output logic [NUM_VREG-1:0][REG_W-1:0] work // Working copies
);

    typedef struct packed {
        logic [NUM_VREG-1:0][REG_W-1:0] host;
        logic [NUM_VREG-1:0][REG_W-1:0] work;
    } vbsm_vl_s;

    vbsm_vl_s s;
    vbsm_vl_s next_s;

    // A write in the boundary cycle lands next field; the field keeps what it had
    always_comb begin
        next_s = s;
        for (int i = 0; i < NUM_VREG; i++) begin
            if (vsync) begin
                next_s.work[i] = s.host[i];
            end
            if (wr_sel[i]) begin
                next_s.host[i] = wr_val;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s <= '0;
        end else if (ce) begin
            s <= next_s;
        end
    end

    assign work = s.work;

endmodule

// *** rtl/vbsm_meas.sv ***
// Tube and picture measurement sequencer.
// Assumes line_start pulses once per line with line_num already valid.
`timescale 1ns/1ps
module vbsm_meas
    import vbsm_pkg::*;
(
    input wire logic clk, // Display clock
    input wire logic rst, // Asynchronous reset
    input wire logic ce, // Clock enable
    input wire logic vsync, // Field boundary pulse
    input wire logic line_start, // Line start pulse
    input wire logic [LINE_W-1:0] line_num, // Current line
    input wire logic tube_en, // Tube measurement enable
    input wire logic [LINE_W-1:0] tube_line, // Tube measurement line
    input wire logic pm_trigger, // Start one picture measurement
    input wire logic [LINE_W-1:0] pm_start, // First measured line
    input wire logic [LINE_W-1:0] pm_stop, // Window closes at the start of this line; last measured line is the one before
    output logic tube_active, // Tube sequence running
    output logic tube_done, // Tube sequence complete
    output logic pic_active, // Picture window open
    output logic pic_done // Picture measurement complete
);

    typedef struct packed {
        vbsm_tm_state_e tm;
        logic [3:0] tm_cnt;
        logic tm_done;
        vbsm_pm_state_e pm;
        logic pm_done;
    } vbsm_ms_s;

    vbsm_ms_s s;
    vbsm_ms_s next_s;

    always_comb begin
        next_s = s;
        case (s.tm)
            VBSM_TM_IDLE: begin
                if (tube_en && line_start && line_num == tube_line) begin
                    next_s.tm = VBSM_TM_RUN;
                    next_s.tm_cnt = TUBE_MEAS_LINES;
                    next_s.tm_done = 1'b0;
                end
            end
            VBSM_TM_RUN: begin
                if (!tube_en) begin
                    next_s.tm = VBSM_TM_IDLE;
                end else if (line_start) begin
                    next_s.tm_cnt = s.tm_cnt - 4'h1;
                    if (s.tm_cnt == 4'h1) begin
                        next_s.tm = VBSM_TM_IDLE;
                        next_s.tm_done = 1'b1;
                    end
                end
            end
            default: next_s.tm = VBSM_TM_IDLE;
        endcase
        case (s.pm)
            VBSM_PM_IDLE: begin
                if (pm_trigger) begin
                    next_s.pm = VBSM_PM_ARM;
                    next_s.pm_done = 1'b0;
                end
            end
            // Wait for the next field boundary so the window is never cut short
            VBSM_PM_ARM: begin
                if (vsync) begin
                    next_s.pm = VBSM_PM_WAIT;
                end
            end
            VBSM_PM_WAIT: begin
                if (line_start && line_num == pm_start) begin
                    next_s.pm = VBSM_PM_RUN;
                end
            end
            VBSM_PM_RUN: begin
                if (line_start && line_num == pm_stop) begin
                    next_s.pm = VBSM_PM_IDLE;
                    next_s.pm_done = 1'b1;
                end
            end
            default: next_s.pm = VBSM_PM_IDLE;
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s <= '{tm: VBSM_TM_IDLE, tm_cnt: 4'h0, tm_done: 1'b0,
                   pm: VBSM_PM_IDLE, pm_done: 1'b0};
        end else if (ce) begin
            s <= next_s;
        end
    end

    assign tube_active = (s.tm == VBSM_TM_RUN);
    assign tube_done = s.tm_done;
    assign pic_active = (s.pm == VBSM_PM_RUN);
    assign pic_done = s.pm_done;

endmodule

// *** rtl/vbsm_regs.sv ***
// Video back end control registers: velocity modulation, cutoff, measurement control.
// Assumes the serial host front end presents decoded subaddress strobes synchronous to clk.
`timescale 1ns/1ps
module vbsm_regs
    import vbsm_pkg::*;
(
    input wire logic clk, // Display clock, 20 MHz
    input wire logic rst, // Asynchronous reset, active high
    input wire logic ce, // Clock enable, freezes all state when low
    input wire logic [ADDR_W-1:0] sub_addr, // Register subaddress
    input wire logic wr_strobe, // One-cycle write strobe
    input wire logic [DATA_W-1:0] wr_data, // Write data
    input wire logic rd_strobe, // One-cycle read strobe
    output logic [DATA_W-1:0] rd_data, // Read data, valid after rd_strobe
    input wire logic vsync, // Field boundary pulse
    input wire logic line_start, // Line start pulse
    input wire logic [LINE_W-1:0] line_num, // Current line number
    input wire logic window_override, // Window disable from the other register bank
    output logic [GAIN_W-1:0] velocity_gain, // Modulation gain
    output logic [DDEL_W-1:0] differentiator_delay, // Differentiator delay code
    output logic diff_filter_on, // Differentiator active
    output logic [LIM_W-1:0] limit_value, // Output clamp
    output logic [HDEL_W-1:0] half_clock_delay, // Delay in half clock steps
    output logic [COR_W-1:0] coring_value, // Coring threshold
    output logic [REG_W-1:0] cutoff_red, // Red black-level offset
    output logic [REG_W-1:0] cutoff_green, // Green black-level offset
    output logic [REG_W-1:0] cutoff_blue, // Blue black-level offset
    output logic tube_meas_enable, // Tube measurement enabled
    output logic picture_meas_bandwidth, // High selects the narrow band
    output logic picture_meas_window_size, // High selects the small window
    output logic tube_meas_active, // Tube measurement running
    output logic pic_meas_active // Picture window open
);

    // ****************
    // Address decode
    // ****************
    function automatic int vreg_index(input logic [ADDR_W-1:0] a);
        case (a)
            ADR_VEL_COEF: vreg_index = VI_COEF;
            ADR_VEL_LIMIT: vreg_index = VI_LIMIT;
            ADR_VEL_DELCOR: vreg_index = VI_DELCOR;
            ADR_CUT_RED: vreg_index = VI_CUT_R;
            ADR_CUT_GREEN: vreg_index = VI_CUT_G;
            ADR_CUT_BLUE: vreg_index = VI_CUT_B;
            ADR_PM_START: vreg_index = VI_PM_START;
            ADR_PM_STOP: vreg_index = VI_PM_STOP;
            ADR_TUBE_LINE: vreg_index = VI_TUBE_LINE;
            default: vreg_index = NUM_VREG;
        endcase
    endfunction

    logic [NUM_VREG-1:0] wr_sel;
    logic [NUM_VREG-1:0][REG_W-1:0] work;

    genvar gi;
    generate
        for (gi = 0; gi < NUM_VREG; gi++) begin : g_sel
            assign wr_sel[gi] = wr_strobe && (vreg_index(sub_addr) == gi);
        end
    endgenerate

    // ****************
    // Field-latched bank
    // ****************
    vbsm_vlatch u_vlatch (
        .clk(clk),
        .rst(rst),
        .ce(ce),
        .wr_sel(wr_sel),
        .wr_val(wr_data[REG_W-1:0]),
        .vsync(vsync),
        .work(work)
    );

    // The working bank is flops; fields are plain slices of it
    assign velocity_gain = work[VI_COEF][GAIN_LSB +: GAIN_W];
    assign differentiator_delay = work[VI_COEF][DDEL_LSB +: DDEL_W];
    // Unused upper limiter bits are ignored; a stray one cannot widen the clamp
    assign limit_value = work[VI_LIMIT][LIM_LSB +: LIM_W];
    assign half_clock_delay = work[VI_DELCOR][HDEL_LSB +: HDEL_W];
    assign coring_value = work[VI_DELCOR][COR_LSB +: COR_W];
    assign cutoff_red = work[VI_CUT_R];
    assign cutoff_green = work[VI_CUT_G];
    assign cutoff_blue = work[VI_CUT_B];

    // ****************
    // Control and read state
    // ****************
    typedef struct packed {
        logic [CTL_W-1:0] ctl;
        logic pm_trigger;
        logic filt_on;
        logic win_small;
        logic [DATA_W-1:0] rd_data;
    } vbsm_rg_s;

    vbsm_rg_s s;
    vbsm_rg_s next_s;
    logic tube_done;
    logic pic_done;
    logic tube_act;
    logic pic_act;

    always_comb begin
        next_s = s;
        next_s.pm_trigger = 1'b0;
        if (wr_strobe && sub_addr == ADR_MEAS_CTL) begin
            next_s.ctl = wr_data[CTL_W-1:0];
            next_s.pm_trigger = wr_data[CTL_PICTURE_MEAS_TRIGGER];
        end
        next_s.filt_on = (work[VI_COEF][DDEL_LSB +: DDEL_W] != DDEL_OFF);
        next_s.win_small = s.ctl[CTL_PICTURE_MEAS_WINDOW_SIZE] && !window_override;
        if (rd_strobe) begin
            next_s.rd_data = '0;
            case (sub_addr)
                ADR_MEAS_CTL: next_s.rd_data[CTL_W-1:0] = s.ctl;
                ADR_STATUS: begin
                    next_s.rd_data[ST_TUBE_DONE] = tube_done;
                    next_s.rd_data[ST_PIC_DONE] = pic_done;
                end
                default: next_s.rd_data = '0;
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s <= '{ctl: CTL_RESET, pm_trigger: 1'b0, filt_on: 1'b0,
                   win_small: 1'b0, rd_data: '0};
        end else if (ce) begin
            s <= next_s;
        end
    end

    // ****************
    // Measurement sequencer
    // ****************
    // Line limits come from the working bank, so a sequence sees one field's values
    vbsm_meas u_meas (
        .clk(clk),
        .rst(rst),
        .ce(ce),
        .vsync(vsync),
        .line_start(line_start),
        .line_num(line_num),
        .tube_en(s.ctl[CTL_TUBE_MEAS_ENABLE]),
        .tube_line(work[VI_TUBE_LINE]),
        .pm_trigger(s.pm_trigger),
        .pm_start(work[VI_PM_START]),
        .pm_stop(work[VI_PM_STOP]),
        .tube_active(tube_act),
        .tube_done(tube_done),
        .pic_active(pic_act),
        .pic_done(pic_done)
    );

    assign rd_data = s.rd_data;
    assign diff_filter_on = s.filt_on;
    assign tube_meas_enable = s.ctl[CTL_TUBE_MEAS_ENABLE];
    assign picture_meas_bandwidth = s.ctl[CTL_PICTURE_MEAS_BANDWIDTH];
    assign picture_meas_window_size = s.win_small;
    assign tube_meas_active = tube_act;
    assign pic_meas_active = pic_act;

endmodule

// *** sim/vbsm_host.sv ***
// Host model: issues one-cycle write and read strobes on the subaddress port.
// Assumes clk is the display clock; requests change on its falling edge.
`timescale 1ns/1ps
module vbsm_host
    import vbsm_pkg::*;
(
    input wire logic clk, // Display clock
    input wire logic [DATA_W-1:0] rd_data, // Read data
    output logic [ADDR_W-1:0] sub_addr, // Subaddress
    output logic wr_strobe, // Write strobe
    output logic [DATA_W-1:0] wr_data, // Write data
    output logic rd_strobe // Read strobe
);
    initial begin
        sub_addr = 8'h00;
        wr_strobe = 1'b0;
        wr_data = 16'h0000;
        rd_strobe = 1'b0;
    end

    task automatic cyc(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d, input logic w);
        @(negedge clk);
        sub_addr = a;
        wr_data = d;
        wr_strobe = w;
        rd_strobe = !w;
        @(negedge clk);
        wr_strobe = 1'b0;
        rd_strobe = 1'b0;
        // Released lines carry junk so a late sample cannot pass by luck
        sub_addr = ~a;
        wr_data = ~d;
    endtask

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        logic [DATA_W-1:0] v;
        v = d;
        if (a == ADR_VEL_LIMIT) begin
            v[8:7] = 2'h0;
        end
        cyc(a, v, 1'b1);
    endtask

    task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
        cyc(a, 16'h0000, 1'b0);
        @(negedge clk);
        d = rd_data;
    endtask
endmodule

// *** sim/vbsm_regs_props.sv ***
// Checker for the back end register bank, watching top-level ports only.
// Assumes one clock domain; bound into every vbsm_regs instance.
`timescale 1ns/1ps
module vbsm_regs_chk
    import vbsm_pkg::*;
(
    input wire logic clk, // In
    input wire logic rst, // In
    input wire logic ce, // In
    input wire logic [ADDR_W-1:0] sub_addr, // In
    input wire logic wr_strobe, // In
    input wire logic [DATA_W-1:0] wr_data, // In
    input wire logic rd_strobe, // In
    input wire logic [DATA_W-1:0] rd_data, // Out
    input wire logic vsync, // In
    input wire logic line_start, // In
    input wire logic window_override, // In
    input wire logic [GAIN_W-1:0] velocity_gain, // Out
    input wire logic [DDEL_W-1:0] differentiator_delay, // Out
    input wire logic diff_filter_on, // Out
    input wire logic [LIM_W-1:0] limit_value, // Out
    input wire logic [HDEL_W-1:0] half_clock_delay, // Out
    input wire logic [REG_W-1:0] cutoff_red, // Out
    input wire logic tube_meas_enable, // Out
    input wire logic picture_meas_bandwidth, // Out
    input wire logic picture_meas_window_size, // Out
    input wire logic tube_meas_active, // Out
    input wire logic pic_meas_active // Out
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence ctl_wr;
        ce && wr_strobe && sub_addr == ADR_MEAS_CTL;
    endsequence
    sequence quiet_field;
        !vsync && !$past(vsync);
    endsequence

    chk_reset_clears: assert property ($fell(rst) |-> !(|{velocity_gain, diff_filter_on,
        limit_value, cutoff_red, tube_meas_enable, pic_meas_active, tube_meas_active}))
        else $error("outputs not clear after reset");
    chk_filter_follows: assert property (ce |=>
        diff_filter_on == ($past(differentiator_delay) != DDEL_OFF))
        else $error("filter enable disagrees with delay code");
    chk_tube_enable: assert property (ctl_wr |=>
        tube_meas_enable == $past(wr_data[CTL_TUBE_MEAS_ENABLE]))
        else $error("tube enable not written");
    chk_band_select: assert property (ctl_wr |=>
        picture_meas_bandwidth == $past(wr_data[CTL_PICTURE_MEAS_BANDWIDTH]))
        else $error("bandwidth select not written");
    chk_window_override: assert property (window_override |=> !picture_meas_window_size)
        else $error("small window despite override");
    chk_field_hold: assert property (quiet_field |=> $stable(velocity_gain)
        && $stable(limit_value) && $stable(half_clock_delay) && $stable(cutoff_red))
        else $error("working value changed outside field boundary");
    chk_tube_start: assert property ($rose(tube_meas_active) |->
        $past(line_start && tube_meas_enable))
        else $error("tube sequence started without line start");
    chk_pic_open: assert property ($rose(pic_meas_active) |-> $past(line_start))
        else $error("picture window opened off a line start");
    chk_tube_abort: assert property (!tube_meas_enable |-> ##[0:2] !tube_meas_active)
        else $error("tube sequence runs while disabled");
    chk_wo_read: assert property (ce && rd_strobe && sub_addr == ADR_VEL_COEF |->
        ##2 rd_data == 16'h0000)
        else $error("write-only register read back nonzero");
endmodule

bind vbsm_regs vbsm_regs_chk u_chk (.clk(clk), .rst(rst), .ce(ce), .sub_addr(sub_addr),
    .wr_strobe(wr_strobe), .wr_data(wr_data), .rd_strobe(rd_strobe), .rd_data(rd_data),
    .vsync(vsync), .line_start(line_start), .window_override(window_override),
    .velocity_gain(velocity_gain), .differentiator_delay(differentiator_delay),
    .diff_filter_on(diff_filter_on), .limit_value(limit_value),
    .half_clock_delay(half_clock_delay), .cutoff_red(cutoff_red),
    .tube_meas_enable(tube_meas_enable), .picture_meas_bandwidth(picture_meas_bandwidth),
    .picture_meas_window_size(picture_meas_window_size),
    .tube_meas_active(tube_meas_active), .pic_meas_active(pic_meas_active));

// *** sim/testbench.sv ***
// Self-checking bench for the back end register bank.
// Assumes the host model drives the subaddress port; video timing comes from here.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin mismatches++; \
    $display("wrong value %s expected %h seen %h", nm, e, g); end end
module testbench
    import vbsm_pkg::*;
;
    logic clk = 1'b0, rst = 1'b1, ce = 1'b1, vsync = 1'b0, line_start = 1'b0;
    logic window_override = 1'b0;
    logic [LINE_W-1:0] line_num = 9'h000;
    logic [ADDR_W-1:0] sub_addr;
    logic wr_strobe, rd_strobe, diff_filter_on, tube_meas_enable, picture_meas_bandwidth;
    logic picture_meas_window_size, tube_meas_active, pic_meas_active;
    logic [DATA_W-1:0] wr_data, rd_data, d;
    logic [GAIN_W-1:0] velocity_gain;
    logic [DDEL_W-1:0] differentiator_delay;
    logic [LIM_W-1:0] limit_value;
    logic [HDEL_W-1:0] half_clock_delay;
    logic [COR_W-1:0] coring_value;
    logic [REG_W-1:0] cutoff_red, cutoff_green, cutoff_blue;
    int mismatches = 0, n_checks = 0, cycles = 0;

    vbsm_host host (.clk(clk), .rd_data(rd_data), .sub_addr(sub_addr), .wr_strobe(wr_strobe),
        .wr_data(wr_data), .rd_strobe(rd_strobe));
    vbsm_regs dut (.clk(clk), .rst(rst), .ce(ce), .sub_addr(sub_addr), .wr_strobe(wr_strobe),
        .wr_data(wr_data), .rd_strobe(rd_strobe), .rd_data(rd_data), .vsync(vsync),
        .line_start(line_start), .line_num(line_num), .window_override(window_override),
        .velocity_gain(velocity_gain), .differentiator_delay(differentiator_delay),
        .diff_filter_on(diff_filter_on), .limit_value(limit_value),
        .half_clock_delay(half_clock_delay), .coring_value(coring_value),
        .cutoff_red(cutoff_red), .cutoff_green(cutoff_green), .cutoff_blue(cutoff_blue),
        .tube_meas_enable(tube_meas_enable), .picture_meas_bandwidth(picture_meas_bandwidth),
        .picture_meas_window_size(picture_meas_window_size),
        .tube_meas_active(tube_meas_active), .pic_meas_active(pic_meas_active));

    initial begin
        forever #25 clk = ~clk;
    end

    // ****************
    // Helpers
    // ****************
    task automatic idle(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic field();
        @(negedge clk);
        vsync = 1'b1;
        @(negedge clk);
        vsync = 1'b0;
        idle(3);
    endtask
    task automatic line(input int n);
        @(negedge clk);
        line_start = 1'b1;
        line_num = n[LINE_W-1:0];
        @(negedge clk);
        line_start = 1'b0;
        idle(1);
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // ****************
    // Scenarios
    // ****************
    task automatic t_reset();
        `CHK("velocity", 1'b0, |{velocity_gain, differentiator_delay, limit_value})
        `CHK("cutoffs", 1'b0, |{cutoff_red, cutoff_green, cutoff_blue})
        `CHK("picture active", 1'b0, pic_meas_active)
        host.rd(ADR_STATUS, d);
        `CHK("status", 16'h0000, d)
        host.rd(ADR_MEAS_CTL, d);
        `CHK("control", 16'h0000, d)
    endtask
    task automatic t_latch();
        host.wr(ADR_VEL_COEF, 16'h0104);
        host.wr(ADR_VEL_LIMIT, 16'h01ff);
        host.wr(ADR_VEL_DELCOR, 16'h00b7);
        host.wr(ADR_CUT_RED, 16'h0101);
        host.wr(ADR_CUT_GREEN, 16'h00aa);
        host.wr(ADR_CUT_BLUE, 16'h0155);
        `CHK("gain early", 6'h00, velocity_gain)
        field();
        `CHK("gain", 6'h04, velocity_gain)
        `CHK("diff delay", 3'h4, differentiator_delay)
        `CHK("filter on", 1'b1, diff_filter_on)
        `CHK("limit", 7'h7f, limit_value)
        `CHK("half delay", 4'h7, half_clock_delay)
        `CHK("coring", 4'hb, coring_value)
        `CHK("red", 9'h101, cutoff_red)
        `CHK("green", 9'h0aa, cutoff_green)
        `CHK("blue", 9'h155, cutoff_blue)
        host.rd(8'h33, d);
        `CHK("unmapped", 16'h0000, d)
        host.rd(ADR_VEL_COEF, d);
        `CHK("write only", 16'h0000, d)
        host.wr(ADR_VEL_COEF, 16'h003f);
        field();
        `CHK("gain max", 6'h3f, velocity_gain)
        `CHK("filter off", 1'b0, diff_filter_on)
    endtask
    task automatic t_control();
        logic [CTL_W-1:0] v;
        for (int i = 0; i < 4; i++) begin
            // Trigger bit is left to the picture scenario: a stray trigger would leave it busy
            if (i == CTL_PICTURE_MEAS_TRIGGER) continue;
            v = 8'h01 << i;
            host.wr(ADR_MEAS_CTL, {8'h00, v});
            idle(2);
            `CHK("tube enable", v[CTL_TUBE_MEAS_ENABLE], tube_meas_enable)
            `CHK("bandwidth", v[CTL_PICTURE_MEAS_BANDWIDTH], picture_meas_bandwidth)
            `CHK("window", v[CTL_PICTURE_MEAS_WINDOW_SIZE], picture_meas_window_size)
            host.rd(ADR_MEAS_CTL, d);
            `CHK("control read", {8'h00, v}, d)
        end
        window_override = 1'b1;
        idle(2);
        `CHK("window overridden", 1'b0, picture_meas_window_size)
        window_override = 1'b0;
        host.wr(ADR_MEAS_CTL, 16'h0000);
    endtask
    task automatic t_tube();
        host.wr(ADR_TUBE_LINE, 16'h0005);
        field();
        host.wr(ADR_MEAS_CTL, 16'h0001);
        idle(2);
        for (int n = 0; n < 20; n++) begin
            line(n);
            if (n == 4) `CHK("tube idle", 1'b0, tube_meas_active)
            if (n == 6) `CHK("tube running", 1'b1, tube_meas_active)
        end
        host.rd(ADR_STATUS, d);
        `CHK("tube done", 1'b1, d[ST_TUBE_DONE])
        // Restart on the tube line, then abort by clearing the enable
        line(5);
        `CHK("tube restarted", 1'b1, tube_meas_active)
        host.wr(ADR_MEAS_CTL, 16'h0000);
        idle(2);
        `CHK("tube aborted", 1'b0, tube_meas_active)
        host.rd(ADR_STATUS, d);
        `CHK("abort not done", 1'b0, d[ST_TUBE_DONE])
    endtask
    task automatic t_picture();
        host.wr(ADR_PM_START, 16'h0014);
        host.wr(ADR_PM_STOP, 16'h0019);
        field();
        host.wr(ADR_MEAS_CTL, 16'h0004);
        host.rd(ADR_STATUS, d);
        `CHK("picture busy", 1'b0, d[ST_PIC_DONE])
        field();
        for (int n = 0; n < 30; n++) begin
            line(n);
            `CHK("window open", 1'(n >= 20 && n < 25), pic_meas_active)
        end
        host.rd(ADR_STATUS, d);
        `CHK("picture done", 1'b1, d[ST_PIC_DONE])
        field();
        for (int n = 18; n < 26; n++) begin
            line(n);
            `CHK("no second cycle", 1'b0, pic_meas_active)
        end
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            print_verdict();
        end
    end

    initial begin
        idle(10);
        rst = 1'b0;
        t_reset();
        t_latch();
        t_control();
        t_tube();
        t_picture();
        print_verdict();
    end
endmodule
